// ==== dv/tb_top.sv ====
// Self-checking bench for the slicer configuration and status bank.
// Assumes the host model drives the register port at falling edges.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk_i = 1'b0, rst_n_i = 1'b0;
    logic tol = 1'b0, ex = 1'b0, one = 1'b0, svc = 1'b0, wide = 1'b0;
    logic cap = 1'b0, fend = 1'b0, ifld = 1'b0, tfld = 1'b0, tvb = 1'b0;
    logic dfld = 1'b0, dvb = 1'b0, bval = 1'b0;
    logic [3:0] dt = 4'hf;
    logic [8:0] ln = 9'h000;
    logic [7:0] bin = 8'h00, addr, wdata, rdata, obyte, afc;
    logic wr, rd, rvalid, upc, acc_o, inr, sfld, svb, sav, obval;
    logic [10:0] slice_horiz_offset;
    logic [8:0] slice_vert_offset;
    logic [5:0] did, sliced_data_sub_id;
    logic [7:0] rq[$], bq[$];
    logic [31:0] seed = 32'h0000_af5e, r;
    logic [6:0] sv[5] = '{7'h7e, 7'h3f, 7'h3e, 7'h7f, 7'h55};
    int failures = 0, checked = 0, cycles = 0, i;

    always #12.5 ref_clk_i = ~ref_clk_i;

    vsc_host host_i (.ref_clk_i(ref_clk_i), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));

    vsc_regs vsc_regs_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .frame_code_err_tolerance_i(tol), .data_type_code_i(dt),
        .code_match_exact_i(ex), .code_match_one_err_i(one),
        .service_hit_i(svc), .widescreen_hit_i(wide),
        .caption_hit_i(cap), .frame_end_i(fend), .internal_field_i(ifld),
        .line_number_i(ln), .table_field_i(tfld), .table_vblank_i(tvb),
        .decoder_field_signal_i(dfld), .decoder_vblank_signal_i(dvb),
        .slice_byte_valid_i(bval), .slice_byte_i(bin),
        .active_frame_code_o(afc), .use_prog_code_o(upc),
        .code_accept_o(acc_o), .slice_horiz_offset_o(slice_horiz_offset),
        .slice_vert_offset_o(slice_vert_offset), .vert_offset_in_range_o(inr),
        .slicer_field_o(sfld), .slicer_vblank_o(svb),
        .sav_eav_framing_o(sav), .anc_did_o(did), .anc_sliced_data_sub_id_o(sliced_data_sub_id),
        .out_byte_valid_o(obval), .out_byte_o(obyte));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        host_i.acc(a, d, 1'b1);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        host_i.acc(a, 8'h00, 1'b0);
    endtask

    task automatic byte_in(input logic [7:0] d, input logic [7:0] e);
        bq.push_back(e);
        @(negedge ref_clk_i);
        bval = 1'b1;
        bin  = d;
        @(negedge ref_clk_i);
        bval = 1'b0;
    endtask

    // Hits land in the same cycle as the frame close
    task automatic frame(input logic [4:0] h);
        @(negedge ref_clk_i);
        {ex, one, svc, wide, cap} = h;
        fend = 1'b1;
        @(negedge ref_clk_i);
        {ex, one, svc, wide, cap} = 5'h00;
        fend = 1'b0;
    endtask

    always @(posedge ref_clk_i) begin
        if (rvalid === 1'b1)
            chk(rdata, rq.size() > 0 ? rq.pop_front() : ~rdata);
        if (obval === 1'b1)
            chk(obyte, bq.size() > 0 ? bq.pop_front() : ~obyte);
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        rreg(8'h58, 8'h40);
        rreg(8'h59, 8'h47);
        rreg(8'h5b, 8'h03);
        rreg(8'h5e, 8'h00);
        rreg(8'h5c, 8'h00);
        chk(slice_horiz_offset, 11'h347);
        r = rnd();
        wreg(8'h58, r[7:0]);
        rreg(8'h58, r[7:0]);
        for (i = 0; i < 16; i++) begin
            @(negedge ref_clk_i);
            dt = i[3:0];
            #1 chk(upc, i inside {8, 9, 10, 13, 14});
            if (i inside {8, 9, 10, 13, 14})
                chk(afc, r[7:0]);
        end
        wreg(8'h5b, 8'hff);
        rreg(8'h5b, 8'hd7);
        wreg(8'h59, 8'h12);
        wreg(8'h5a, 8'h38);
        chk(slice_horiz_offset, 11'h712);
        chk(slice_vert_offset, 9'h138);
        chk(inr, 1'b1);
        wreg(8'h5a, 8'h39);
        chk(inr, 1'b0);
        for (i = 0; i < 2; i++) begin
            wreg(8'h5b, i ? 8'h03 : 8'h43);
            byte_in(8'h00, i ? 8'h00 : 8'h03);
            byte_in(8'hff, i ? 8'hff : 8'hfc);
            byte_in(8'h5a, 8'h5a);
        end
        host_i.std_slice_vert_offset(1'b0);
        chk(slice_vert_offset, 9'h003);
        host_i.std_slice_vert_offset(1'b1);
        chk(slice_vert_offset, 9'h006);
        for (i = 0; i < 4; i++) begin
            wreg(8'h5b, {i[0], 7'h03});
            wreg(8'h5d, {i[1], 7'h00});
            r = rnd();
            @(negedge ref_clk_i);
            {dvb, dfld, tvb, tfld} = r[3:0];
            #1 chk(sfld, i[1] ? r[2] : r[0] ^ i[0]);
            chk(svb, i[1] ? r[3] : r[1]);
        end
        for (i = 0; i < 5; i++) begin
            wreg(8'h5d, {sv[i][6], 1'b0, sv[i][5:0]});
            chk(sav, sv[i] == 7'h7e || sv[i] == 7'h3f);
            chk(did, sv[i][5:0]);
            rreg(8'h5d, {sv[i][6], 1'b0, sv[i][5:0]});
        end
        wreg(8'h5e, 8'hff);
        rreg(8'h5e, 8'h3f);
        chk(sliced_data_sub_id, 6'h3f);
        for (i = 0; i < 8; i++) begin
            @(negedge ref_clk_i);
            {tol, ex, one} = i[2:0];
            #1 chk(acc_o, ex | (one & ~tol));
        end
        frame(5'h00);
        frame(5'h15);
        rreg(8'h60, 8'h54);
        frame(5'h0a);
        rreg(8'h60, 8'h28);
        frame(5'h00);
        wreg(8'h60, 8'hff);
        rreg(8'h60, 8'h00);
        @(negedge ref_clk_i);
        ln = 9'h1a5;
        dt = 4'h6;
        ifld = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        rreg(8'h62, 8'h56);
        wreg(8'h61, 8'h00);
        wreg(8'h62, 8'h00);
        // Field inversion is still set here, so field 2 reads back as 0
        rreg(8'h61, 8'h1a);
        ifld = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        rreg(8'h61, 8'h3a);
        wreg(8'h5b, 8'h03);
        repeat (2) @(negedge ref_clk_i);
        rreg(8'h61, 8'h1a);
        repeat (3) @(negedge ref_clk_i);
        chk(rq.size() + bq.size(), 16'h0000);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire

// ==== dv/vsc_host.sv ====
// Host model for the slicer register bank: subaddressed byte accesses.
// Assumes strobes are sampled on the rising edge of ref_clk_i.
`default_nettype none
module vsc_host (
    input  wire logic       ref_clk_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end

    // One strobe cycle, then an idle cycle before the next access
    task automatic acc(input logic [7:0] a, input logic [7:0] d,
                       input logic w);
        @(negedge ref_clk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = w;
        reg_rd_o    = !w;
        @(negedge ref_clk_i);
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        // Idle lines flip so a stale value is never mistaken for live data
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask

    // Standard vertical offsets leave the ninth bit as already cleared
    task automatic std_slice_vert_offset(input logic is525);
        acc(8'h5a, is525 ? 8'h06 : 8'h03, 1'b1);
    endtask
endmodule // vsc_host
`default_nettype wire

// ==== rtl/vsc_pkg.sv ====
// Package for the slicer configuration and status register bank.
// Assumes a byte-wide subaddressed register port driven by a serial host.
`default_nettype none
package vsc_pkg;
    localparam logic [7:0] ADDR_FRAME_CODE   = 8'h58;
    localparam logic [7:0] ADDR_SLICE_HORIZ_OFFSET_LOW     = 8'h59;
    localparam logic [7:0] ADDR_SLICE_VERT_OFFSET_LOW     = 8'h5a;
    localparam logic [7:0] ADDR_FIELD_MSBS   = 8'h5b;
    localparam logic [7:0] ADDR_ANC_ID       = 8'h5d;
    localparam logic [7:0] ADDR_SLICED_DATA_SUB_ID         = 8'h5e;
    localparam logic [7:0] ADDR_STAT_DETECT  = 8'h60;
    localparam logic [7:0] ADDR_STAT_LINE_HI = 8'h61;
    localparam logic [7:0] ADDR_STAT_LINE_LO = 8'h62;

    localparam logic [7:0]  RST_FRAME_CODE = 8'h40;
    localparam logic [10:0] RST_SLICE_HORIZ_OFFSET       = 11'h347;
    localparam logic [8:0]  RST_SLICE_VERT_OFFSET       = 9'h003;
    localparam logic [5:0]  RST_DID        = 6'h00;
    localparam logic [5:0]  RST_SLICED_DATA_SUB_ID       = 6'h00;

    localparam int FLD_INVERT_BIT  = 7;
    localparam int FLD_RECODE_BIT  = 6;
    localparam int FLD_SLICE_VERT_OFFSET_MSB_BIT   = 4;
    localparam int FLD_FV_REFERENCE_SELECT_BIT   = 7;
    localparam int LINE_MAX        = 312;

    localparam logic [5:0] DID_SAV_FVREF1 = 6'h3e;
    localparam logic [5:0] DID_SAV_FVREF0 = 6'h3f;

    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [7:0] BYTE_ONES      = 8'hff;
    localparam logic [7:0] BYTE_ZERO_REPL = 8'h03;
    localparam logic [7:0] BYTE_ONES_REPL = 8'hfc;

    localparam logic [3:0] DT_GEN_TEXT = 4'b1000;
    localparam logic [3:0] DT_VITC625  = 4'b1001;
    localparam logic [3:0] DT_VITC525  = 4'b1010;
    localparam logic [3:0] DT_JAPTEXT  = 4'b1101;
    localparam logic [3:0] DT_JFS      = 4'b1110;
endpackage : vsc_pkg
`default_nettype wire

// ==== rtl/vsc_recode.sv ====
// Sliced output byte recoder: removes reserved 00h and FFh codes.
// Assumes bytes arrive with a valid strobe on the decoder clock.
`default_nettype none
module vsc_recode (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       recode_en_i,
    input  wire logic       byte_valid_i,
    input  wire logic [7:0] byte_i,
    output logic            byte_valid_o,
    output logic      [7:0] byte_o
);
    logic [7:0] mapped;

    always_comb begin
        mapped = byte_i;
        if (recode_en_i && byte_i == vsc_pkg::BYTE_ZERO) begin
            mapped = vsc_pkg::BYTE_ZERO_REPL;
        end else if (recode_en_i && byte_i == vsc_pkg::BYTE_ONES) begin
            mapped = vsc_pkg::BYTE_ONES_REPL;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            byte_valid_o <= 1'b0;
            byte_o       <= 8'h00;
        end else begin
            byte_valid_o <= byte_valid_i;
            byte_o       <= mapped;
        end
    end

    property p_recode_map;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        byte_valid_i |=> (byte_o == ($past(recode_en_i) ?
            (($past(byte_i) == 8'h00) ? 8'h03 :
             ($past(byte_i) == 8'hff) ? 8'hfc : $past(byte_i)) :
            $past(byte_i)));
    endproperty
    a_recode_map: assert property (p_recode_map)
        else $error("Recoded byte mismatch");
endmodule // vsc_recode
`default_nettype wire

// ==== rtl/vsc_regs.sv ====
// Slicer configuration and status register bank behind a subaddressed port.
// Assumes the serial host front end issues one-cycle read/write strobes.
`default_nettype none
module vsc_regs (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // Subaddressed register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_rvalid_o,
    // Slicer core interface
    input  wire logic       frame_code_err_tolerance_i,
    input  wire logic [3:0] data_type_code_i,
    input  wire logic       code_match_exact_i,
    input  wire logic       code_match_one_err_i,
    input  wire logic       service_hit_i,
    input  wire logic       widescreen_hit_i,
    input  wire logic       caption_hit_i,
    input  wire logic       frame_end_i,
    input  wire logic       internal_field_i,
    input  wire logic [8:0] line_number_i,
    input  wire logic       table_field_i,
    input  wire logic       table_vblank_i,
    input  wire logic       decoder_field_signal_i,
    input  wire logic       decoder_vblank_signal_i,
    input  wire logic       slice_byte_valid_i,
    input  wire logic [7:0] slice_byte_i,
    // Configuration outputs toward the slicer, then the recoded output byte stream
    output logic      [7:0] active_frame_code_o,
    output logic            use_prog_code_o,
    output logic            code_accept_o,
    output logic     [10:0] slice_horiz_offset_o,
    output logic      [8:0] slice_vert_offset_o,
    output logic            vert_offset_in_range_o,
    output logic            slicer_field_o,
    output logic            slicer_vblank_o,
    output logic            sav_eav_framing_o,
    output logic      [5:0] anc_did_o,
    output logic      [5:0] anc_sliced_data_sub_id_o,
    output logic            out_byte_valid_o,
    output logic      [7:0] out_byte_o
);
    logic [7:0]  prog_frame_code_reg;
    logic [10:0] slice_horiz_offset_reg;
    logic [8:0]  slice_vert_offset_reg;
    logic        field_invert_reg;
    logic        recode_reg;
    logic        fv_reference_select_reg;
    logic [5:0]  anc_did_reg;
    logic [5:0]  anc_sliced_data_sub_id_reg;

    logic frame_code_exact_seen_reg;
    logic frame_code_one_err_seen_reg;
    logic program_service_seen_reg;
    logic widescreen_seen_reg;
    logic caption_seen_reg;
    logic frame_code_exact_acc_reg;
    logic frame_code_one_err_acc_reg;
    logic program_service_acc_reg;
    logic widescreen_acc_reg;
    logic caption_acc_reg;

    logic       slicer_field_id_reg;
    logic [8:0] line_number_reg;
    logic [3:0] data_type_code_reg;
    logic [7:0] rdata_next;
    logic       fv_field;

    // Configuration writes; status addresses fall through untouched.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            prog_frame_code_reg     <= vsc_pkg::RST_FRAME_CODE;
            slice_horiz_offset_reg  <= vsc_pkg::RST_SLICE_HORIZ_OFFSET;
            slice_vert_offset_reg   <= vsc_pkg::RST_SLICE_VERT_OFFSET;
            field_invert_reg        <= 1'b0;
            recode_reg              <= 1'b0;
            fv_reference_select_reg <= 1'b0;
            anc_did_reg             <= vsc_pkg::RST_DID;
            anc_sliced_data_sub_id_reg            <= vsc_pkg::RST_SLICED_DATA_SUB_ID;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                vsc_pkg::ADDR_FRAME_CODE: begin
                    prog_frame_code_reg <= reg_wdata_i;
                end
                vsc_pkg::ADDR_SLICE_HORIZ_OFFSET_LOW: begin
                    slice_horiz_offset_reg[7:0] <= reg_wdata_i;
                end
                vsc_pkg::ADDR_SLICE_VERT_OFFSET_LOW: begin
                    slice_vert_offset_reg[7:0] <= reg_wdata_i;
                end
                vsc_pkg::ADDR_FIELD_MSBS: begin
                    field_invert_reg <= reg_wdata_i[vsc_pkg::FLD_INVERT_BIT];
                    recode_reg       <= reg_wdata_i[vsc_pkg::FLD_RECODE_BIT];
                    slice_vert_offset_reg[8] <=
                        reg_wdata_i[vsc_pkg::FLD_SLICE_VERT_OFFSET_MSB_BIT];
                    slice_horiz_offset_reg[10:8] <= reg_wdata_i[2:0];
                end
                vsc_pkg::ADDR_ANC_ID: begin
                    fv_reference_select_reg <=
                        reg_wdata_i[vsc_pkg::FLD_FV_REFERENCE_SELECT_BIT];
                    anc_did_reg <= reg_wdata_i[5:0];
                end
                vsc_pkg::ADDR_SLICED_DATA_SUB_ID: begin
                    anc_sliced_data_sub_id_reg <= reg_wdata_i[5:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Per-frame accumulators; results latch at frame end so a read shows
    // the last complete frame rather than a partial one.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            frame_code_exact_acc_reg   <= 1'b0;
            frame_code_one_err_acc_reg <= 1'b0;
            program_service_acc_reg    <= 1'b0;
            widescreen_acc_reg         <= 1'b0;
            caption_acc_reg            <= 1'b0;
        end else if (frame_end_i) begin
            frame_code_exact_acc_reg   <= 1'b0;
            frame_code_one_err_acc_reg <= 1'b0;
            program_service_acc_reg    <= 1'b0;
            widescreen_acc_reg         <= 1'b0;
            caption_acc_reg            <= 1'b0;
        end else begin
            frame_code_exact_acc_reg   <= frame_code_exact_acc_reg
                                          | code_match_exact_i;
            frame_code_one_err_acc_reg <= frame_code_one_err_acc_reg
                                          | code_match_one_err_i;
            program_service_acc_reg    <= program_service_acc_reg
                                          | service_hit_i;
            widescreen_acc_reg         <= widescreen_acc_reg
                                          | widescreen_hit_i;
            caption_acc_reg            <= caption_acc_reg | caption_hit_i;
        end
    end

    // Hits in the frame-end cycle still count for the frame just closed.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            frame_code_exact_seen_reg   <= 1'b0;
            frame_code_one_err_seen_reg <= 1'b0;
            program_service_seen_reg    <= 1'b0;
            widescreen_seen_reg         <= 1'b0;
            caption_seen_reg            <= 1'b0;
        end else if (frame_end_i) begin
            frame_code_exact_seen_reg   <= frame_code_exact_acc_reg
                                           | code_match_exact_i;
            frame_code_one_err_seen_reg <= frame_code_one_err_acc_reg
                                           | code_match_one_err_i;
            program_service_seen_reg    <= program_service_acc_reg
                                           | service_hit_i;
            widescreen_seen_reg         <= widescreen_acc_reg
                                           | widescreen_hit_i;
            caption_seen_reg            <= caption_acc_reg
                                           | caption_hit_i;
        end
    end

    // Field, line and type snapshot, captured together for consistency.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            slicer_field_id_reg <= 1'b0;
            line_number_reg     <= 9'h000;
            data_type_code_reg  <= 4'h0;
        end else begin
            // The slicer's own field view carries the inversion option
            slicer_field_id_reg <= internal_field_i ^ field_invert_reg;
            line_number_reg     <= line_number_i;
            data_type_code_reg  <= data_type_code_i;
        end
    end

    // Field indicator: reference selection; the optional inversion applies to the table field only.
    always_comb begin
        if (fv_reference_select_reg) begin
            fv_field        = decoder_field_signal_i;
            slicer_vblank_o = decoder_vblank_signal_i;
        end else begin
            fv_field        = table_field_i ^ field_invert_reg;
            slicer_vblank_o = table_vblank_i;
        end
    end

    assign slicer_field_o = fv_field;

    assign sav_eav_framing_o =
        (fv_reference_select_reg && anc_did_reg == vsc_pkg::DID_SAV_FVREF1)
        || (!fv_reference_select_reg
            && anc_did_reg == vsc_pkg::DID_SAV_FVREF0);
    assign anc_did_o  = anc_did_reg;
    assign anc_sliced_data_sub_id_o = anc_sliced_data_sub_id_reg;

    assign use_prog_code_o = (data_type_code_i == vsc_pkg::DT_GEN_TEXT)
                          || (data_type_code_i == vsc_pkg::DT_VITC625)
                          || (data_type_code_i == vsc_pkg::DT_VITC525)
                          || (data_type_code_i == vsc_pkg::DT_JAPTEXT)
                          || (data_type_code_i == vsc_pkg::DT_JFS);
    assign active_frame_code_o = prog_frame_code_reg;
    assign code_accept_o = code_match_exact_i
                        || (!frame_code_err_tolerance_i
                            && code_match_one_err_i);

    assign slice_horiz_offset_o   = slice_horiz_offset_reg;
    assign slice_vert_offset_o    = slice_vert_offset_reg;
    assign vert_offset_in_range_o =
        ({23'd0, slice_vert_offset_reg} <= vsc_pkg::LINE_MAX);

    // Readback; status words are assembled from snapshot registers only.
    always_comb begin
        case (reg_addr_i)
            vsc_pkg::ADDR_FRAME_CODE:  rdata_next = prog_frame_code_reg;
            vsc_pkg::ADDR_SLICE_HORIZ_OFFSET_LOW:    rdata_next =
                slice_horiz_offset_reg[7:0];
            vsc_pkg::ADDR_SLICE_VERT_OFFSET_LOW:    rdata_next =
                slice_vert_offset_reg[7:0];
            vsc_pkg::ADDR_FIELD_MSBS:  rdata_next = {field_invert_reg,
                recode_reg, 1'b0, slice_vert_offset_reg[8], 1'b0,
                slice_horiz_offset_reg[10:8]};
            vsc_pkg::ADDR_ANC_ID:      rdata_next = {fv_reference_select_reg,
                1'b0, anc_did_reg};
            vsc_pkg::ADDR_SLICED_DATA_SUB_ID:        rdata_next = {2'b00, anc_sliced_data_sub_id_reg};
            vsc_pkg::ADDR_STAT_DETECT: rdata_next = {1'b0,
                frame_code_exact_seen_reg, frame_code_one_err_seen_reg,
                program_service_seen_reg, widescreen_seen_reg,
                caption_seen_reg, 2'b00};
            vsc_pkg::ADDR_STAT_LINE_HI: rdata_next = {2'b00,
                slicer_field_id_reg, line_number_reg[8:4]};
            vsc_pkg::ADDR_STAT_LINE_LO: rdata_next = {line_number_reg[3:0],
                data_type_code_reg};
            default:                   rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_next;
            end
        end
    end

    vsc_recode u_recode (
        .ref_clk_i    (ref_clk_i),
        .rst_n_i      (rst_n_i),
        .recode_en_i  (recode_reg),
        .byte_valid_i (slice_byte_valid_i),
        .byte_i       (slice_byte_i),
        .byte_valid_o (out_byte_valid_o),
        .byte_o       (out_byte_o)
    );

    property p_fc_write;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == vsc_pkg::ADDR_FRAME_CODE |=>
        prog_frame_code_reg == $past(reg_wdata_i);
    endproperty
    a_fc_write: assert property (p_fc_write)
        else $error("Frame code write not stored");
    property p_slice_horiz_offset_hi;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == vsc_pkg::ADDR_FIELD_MSBS |=>
        slice_horiz_offset_o[10:8] == $past(reg_wdata_i[2:0])
        && slice_vert_offset_o[8] == $past(reg_wdata_i[4]);
    endproperty
    a_slice_horiz_offset_hi: assert property (p_slice_horiz_offset_hi)
        else $error("Offset msbs not stored");
    property p_sav;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        sav_eav_framing_o |-> anc_did_o[5:1] == 5'h1f
        && (anc_did_o[0] != fv_reference_select_reg);
    endproperty
    a_sav: assert property (p_sav)
        else $error("SAV/EAV select wrong");
    property p_ro;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == vsc_pkg::ADDR_STAT_DETECT && !frame_end_i
        |=> $stable(caption_seen_reg) && $stable(widescreen_seen_reg)
        && $stable(program_service_seen_reg)
        && $stable(frame_code_exact_seen_reg)
        && $stable(frame_code_one_err_seen_reg);
    endproperty
    a_ro: assert property (p_ro)
        else $error("Status changed by write");
    property p_caption;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        frame_end_i && caption_hit_i |=> caption_seen_reg;
    endproperty
    a_caption: assert property (p_caption)
        else $error("Caption flag lost");
    property p_exact;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        frame_end_i && code_match_exact_i |=> frame_code_exact_seen_reg;
    endproperty
    a_exact: assert property (p_exact)
        else $error("Exact code flag lost");
    property p_line;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == vsc_pkg::ADDR_STAT_LINE_LO |=>
        reg_rvalid_o && reg_rdata_o[3:0] == $past(data_type_code_reg);
    endproperty
    a_line: assert property (p_line)
        else $error("Type readback wrong");
    property p_tol;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        frame_code_err_tolerance_i && !code_match_exact_i |-> !code_accept_o;
    endproperty
    a_tol: assert property (p_tol)
        else $error("Errored code accepted");
    property p_field_id;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        rst_n_i |=> slicer_field_id_reg
            == ($past(internal_field_i) ^ $past(field_invert_reg));
    endproperty
    a_field_id: assert property (p_field_id)
        else $error("Field identity snapshot wrong");
endmodule // vsc_regs
`default_nettype wire
